// ### core/sst_pkg.sv
// Constants for the clocked-mode serial master transmitter.
// Assumes a Wishbone classic register bus with 32-bit data.
package sst_pkg;
  // Register word byte addresses
  localparam logic [3:0] SST_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] SST_ADDR_BAUD   = 4'h4;
  localparam logic [3:0] SST_ADDR_TXBUF  = 4'h8;
  localparam logic [3:0] SST_ADDR_STATUS = 4'hC;
  // Control register bit positions
  localparam int SST_CTL_SYNC  = 0;
  localparam int SST_CTL_SPON  = 1;
  localparam int SST_CTL_MSTR  = 2;
  localparam int SST_CTL_SINGLE_RECEIVE_ON  = 3;
  localparam int SST_CTL_CONTINUOUS_RECEIVE_ON  = 4;
  localparam int SST_CTL_TXON  = 5;
  localparam int SST_CTL_NINE  = 6;
  localparam int SST_CTL_NVAL  = 7;
  localparam int SST_CTL_POL   = 8;
  localparam int SST_CTL_HSPD  = 9;
  localparam int SST_CTL_WIDE  = 10;
  localparam int SST_CTL_IRQEN = 11;
  localparam int SST_CTL_W     = 12;
  // Status register bit positions
  localparam int SST_ST_EMPTY = 0;
  localparam int SST_ST_BUSY  = 1;
  localparam int SST_ST_IRQ   = 2;
  localparam int SST_ST_DIN   = 3;
  // Reset values
  localparam logic [SST_CTL_W-1:0] SST_CTRL_RST = 12'h000;
  localparam logic [15:0]          SST_BAUD_RST = 16'h0000;
  // Shift engine states
  typedef enum logic [1:0] {
    SST_IDLE = 2'b00,
    SST_LEAD = 2'b01,
    SST_TRAIL = 2'b10
  } sst_state_e;
endpackage

// ### core/sst_master_tx.sv
// Clocked-mode serial master transmitter with Wishbone register file.
// Assumes a single core clock; pins are joined outside by the bench.
//
// Function
// RQ1 - Data leaves on the shared data pin
// RQ2 - Data and clock drivers enable automatically
// RQ3 - Buffer write starts a transmission
// RQ4 - New character waits while shifter busy
// RQ5 - Empty shifter loads buffer at once
// RQ6 - Shifting starts right after the load
// RQ7 - Data changes on leading clock edge
// RQ8 - Shift register is not software visible
// RQ9 - Software programs baud divisor before sending
// RQ10 - Software selects clocked master, port on
// RQ11 - Software turns both receive enables off
// RQ12 - Software sets transmit enable first
// RQ13 - Ninth-bit enable sends nine bits
// RQ14 - Software loads ninth value before character
// RQ15 - Software sets interrupt enables for irq
// RQ16 - Character load is the last setup step
// RQ17 - One clock per bit, no extra
// RQ18 - Polarity sets idle level and edge
// RQ19 - No start or stop bits
// RQ20 - Master drives the shared clock pin
// RQ21 - Buffer-empty flag on transfer, gated irq
// RQ22 - Idle clock held when nothing pending
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module sst_master_tx
  import sst_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              i_core_clk,   // Core clock 200 MHz
  input  wire logic              i_rst_n,      // Async reset, active low
  input  wire logic              i_wb_cyc,     // Bus cycle
  input  wire logic              i_wb_stb,     // Bus strobe
  input  wire logic              i_wb_we,      // Write enable
  input  wire logic [3:0]        i_wb_adr,     // Byte address
  input  wire logic [3:0]        i_wb_sel,     // Byte lanes
  input  wire logic [31:0]       i_wb_dat,     // Write data
  output logic      [31:0]       o_wb_dat,     // Read data
  output logic                   o_wb_ack,     // Acknowledge
  input  wire logic              i_data_in,    // Shared data pin level
  output logic                   o_data_out,   // Shared data pin drive
  output logic                   o_data_oe_n,  // Data pin enable, low drives
  output logic                   o_clk_out,    // Shared clock pin drive
  output logic                   o_clk_oe_n,   // Clock pin enable, low drives
  output logic                   o_irq         // Transmit interrupt request
);
  import sst_pkg::*;

  // Shift width must fit the bit counter and the low write lanes
  if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
    $error("DATA_W out of range");
  end

  logic [SST_CTL_W-1:0] ctrl_q;
  logic [15:0]          baud_q;
  logic [DATA_W-1:0]    txbuf_q;
  logic                 txbuf_full_q;
  logic [DATA_W:0]      shift_q;       // Hidden shift register
  logic [4:0]           bits_left_q;
  logic [15:0]          div_cnt_q;
  logic                 empty_flag_q;
  sst_state_e           state_q;
  logic                 din_s1_q, din_s2_q;

  // Ack low gates the request so a held strobe is not taken again in its ack cycle
  wire bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr   = bus_req & i_wb_we;
  wire wr_txbuf = bus_wr & (i_wb_adr == SST_ADDR_TXBUF) & i_wb_sel[0];
  wire rd_stat  = bus_req & ~i_wb_we & (i_wb_adr == SST_ADDR_STATUS);
  wire mode_ok  = ctrl_q[SST_CTL_SYNC] & ctrl_q[SST_CTL_SPON] & ctrl_q[SST_CTL_MSTR]
                & ~ctrl_q[SST_CTL_SINGLE_RECEIVE_ON] & ~ctrl_q[SST_CTL_CONTINUOUS_RECEIVE_ON];
  wire tx_ok    = mode_ok & ctrl_q[SST_CTL_TXON];
  wire pol      = ctrl_q[SST_CTL_POL];
  wire nine     = ctrl_q[SST_CTL_NINE];
  wire half_tick = (div_cnt_q == 16'h0000);
  wire shifter_free = (state_q == SST_IDLE);
  wire load_now = tx_ok & txbuf_full_q & shifter_free;

  // Half bit period less one, in core clocks, wide or narrow divisor
  wire [15:0] div_reload = ctrl_q[SST_CTL_WIDE] ? baud_q : {8'h00, baud_q[7:0]};

  // Data pin input synchroniser, level only read back by software
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= i_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_wb_ack <= 1'b0;
    else          o_wb_ack <= bus_req;
  end

  // Control and baud registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= SST_CTRL_RST;
      baud_q <= SST_BAUD_RST;
    end else if (bus_wr) begin
      if (i_wb_adr == SST_ADDR_CTRL) begin
        if (i_wb_sel[0]) ctrl_q[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1]) ctrl_q[SST_CTL_W-1:8] <= i_wb_dat[SST_CTL_W-1:8];
      end
      if (i_wb_adr == SST_ADDR_BAUD) begin
        if (i_wb_sel[0]) baud_q[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) baud_q[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // Read mux; shift register has no address
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (bus_req && !i_wb_we) begin
      o_wb_dat <= 32'h0000_0000; // RQ8
      case (i_wb_adr)
        SST_ADDR_CTRL:   o_wb_dat[SST_CTL_W-1:0] <= ctrl_q;
        SST_ADDR_BAUD:   o_wb_dat[15:0] <= baud_q;
        SST_ADDR_STATUS: begin
          o_wb_dat[SST_ST_EMPTY] <= empty_flag_q;
          o_wb_dat[SST_ST_BUSY]  <= ~shifter_free;
          o_wb_dat[SST_ST_IRQ]   <= o_irq;
          o_wb_dat[SST_ST_DIN]   <= din_s2_q;
        end
        default:         o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  // Transmit buffer holds a write until the shifter frees
  // A write landing with a load keeps it full; the shifter takes the old word
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txbuf_q      <= '0;
      txbuf_full_q <= 1'b0;
    end else if (wr_txbuf) begin
      txbuf_q      <= i_wb_dat[DATA_W-1:0]; // RQ3
      txbuf_full_q <= 1'b1;                 // RQ4
    end else if (load_now) begin
      txbuf_full_q <= 1'b0;                 // RQ5
    end
  end

  // Buffer-empty flag: set on transfer, cleared by status read; set wins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)      empty_flag_q <= 1'b0;
    else if (load_now) empty_flag_q <= 1'b1; // RQ21
    else if (rd_stat)  empty_flag_q <= 1'b0;
  end

  // Interrupt request gated by enable
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_irq <= 1'b0;
    else          o_irq <= empty_flag_q & ctrl_q[SST_CTL_IRQEN]; // RQ21
  end

  // Shift engine: lead half drives data, trail half completes clock
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= SST_IDLE;
      shift_q     <= '0;
      bits_left_q <= 5'h00;
      div_cnt_q   <= 16'h0000;
      o_clk_out   <= 1'b0;
      o_data_out  <= 1'b0;
    end else begin
      case (state_q)
        SST_IDLE: begin
          o_clk_out <= pol;                  // RQ22 RQ18
          if (load_now) begin
            // Data bits only, ninth bit on top
            shift_q     <= {ctrl_q[SST_CTL_NVAL], txbuf_q}; // RQ19 RQ13
            bits_left_q <= nine ? 5'(DATA_W + 1) : 5'(DATA_W); // RQ17
            div_cnt_q   <= 16'h0000;
            state_q     <= SST_LEAD;         // RQ6
          end
        end
        SST_LEAD: begin
          if (half_tick) begin
            o_clk_out   <= ~pol;             // RQ7 RQ18
            o_data_out  <= shift_q[0];       // RQ1 RQ7
            shift_q     <= {1'b0, shift_q[DATA_W:1]};
            bits_left_q <= bits_left_q - 5'h01;
            div_cnt_q   <= div_reload;
            state_q     <= SST_TRAIL;
          end else begin
            div_cnt_q <= div_cnt_q - 16'h0001;
          end
        end
        SST_TRAIL: begin
          if (half_tick) begin
            o_clk_out <= pol;                // RQ17
            div_cnt_q <= div_reload;
            state_q   <= (bits_left_q == 5'h00) ? SST_IDLE : SST_LEAD; // RQ4
          end else begin
            div_cnt_q <= div_cnt_q - 16'h0001;
          end
        end
        default: state_q <= SST_IDLE;
      endcase
    end
  end

  // Data driver enabled by master transmit mode, clock driver by master mode alone
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_oe_n <= 1'b1;
      o_clk_oe_n  <= 1'b1;
    end else begin
      o_data_oe_n <= ~tx_ok;                 // RQ2 RQ1
      o_clk_oe_n  <= ~mode_ok;               // RQ2 RQ20
    end
  end
endmodule

// ### testbench/sst_master_tx_asserts.sv
// Port checks for the clocked serial master transmitter.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module sst_master_tx_chk
  import sst_pkg::*;
(
  input wire logic        i_core_clk,  // Core clock
  input wire logic        i_rst_n,     // Reset, active low
  input wire logic        i_wb_cyc,    // Bus cycle
  input wire logic        i_wb_stb,    // Bus strobe
  input wire logic        i_wb_we,     // Write enable
  input wire logic [3:0]  i_wb_adr,    // Address
  input wire logic [3:0]  i_wb_sel,    // Lanes
  input wire logic [31:0] o_wb_dat,    // Read data
  input wire logic        o_wb_ack,    // Ack
  input wire logic        o_data_out,  // Data drive
  input wire logic        o_data_oe_n, // Data enable
  input wire logic        o_clk_out,   // Clock drive
  input wire logic        o_clk_oe_n   // Clock enable
);
  logic       clk_q;
  logic [6:0] idle_q;
  logic       chg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Clock line movement and quiet time
  assign chg = clk_q != o_clk_out;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_q  <= 1'b0;
      idle_q <= 7'h00;
    end else begin
      clk_q  <= o_clk_out;
      idle_q <= chg ? 7'h00 : idle_q + 7'(idle_q != 7'h7F);
    end
  end
  property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_ack_cause; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_buf_hidden;
    i_wb_cyc && i_wb_stb && !i_wb_we && i_wb_adr == SST_ADDR_TXBUF && !o_wb_ack
      |=> o_wb_dat == 32'h0;
  endproperty
  a_buf_hidden: assert property (p_buf_hidden) else $error("buffer readable");
  property p_oe_pair; !o_data_oe_n |-> !o_clk_oe_n; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock not driven");
  property p_clk_driven; chg |-> !o_clk_oe_n; endproperty
  a_clk_driven: assert property (p_clk_driven) else $error("clock undriven");
  property p_data_lead;
    !o_data_oe_n && $past(!o_data_oe_n) && $changed(o_data_out) |-> chg;
  endproperty
  a_data_lead: assert property (p_data_lead) else $error("data off edge");
  property p_start_prompt;
    idle_q == 7'h7F && !o_data_oe_n && o_wb_ack && i_wb_we && i_wb_adr == SST_ADDR_TXBUF
      && i_wb_sel[0] |=> !chg ##[1:2] chg;
  endproperty
  a_start_prompt: assert property (p_start_prompt) else $error("late start");
endmodule
bind sst_master_tx sst_master_tx_chk u_chk (.i_core_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_data_out, .o_data_oe_n,
  .o_clk_out, .o_clk_oe_n);

// ### testbench/sst_slave_model.sv
// Slave on the link: takes a bit at each trailing clock edge.
// Assumes clock and data lines resolved by the bench.
`timescale 1ns/10ps
module sst_slave_model (
  input  wire logic        i_core_clk, // Sampling clock
  input  wire logic        i_clk_line, // Link clock line
  input  wire logic        i_data_line,// Link data line
  input  wire logic        i_pol,      // Idle level
  input  wire logic        i_clr,      // Clear capture
  output logic [4:0]       o_cnt,      // Bits taken
  output logic [17:0]      o_rx        // Bits, first at 0
);
  logic prev_q;
  // Trailing edge is the move back to idle level
  always_ff @(posedge i_core_clk) begin
    prev_q <= i_clk_line;
    if (i_clr) begin
      o_cnt <= 5'h00;
      o_rx  <= 18'h0;
    end else if (prev_q != i_clk_line && i_clk_line == i_pol && o_cnt < 5'd18) begin
      o_rx[o_cnt] <= i_data_line;
      o_cnt       <= o_cnt + 5'h01;
    end
  end
endmodule

// ### testbench/sst_master_tx_bench.sv
// Bench for the clocked serial master transmitter.
// Drives Wishbone, checks the link through a slave model.
`timescale 1ns/10ps
module sst_master_tx_bench
  import sst_pkg::*;
;
  logic clk = 0, rst_n, cyc, stb, we, ack, dout, doe_n, cout, coe_n, irq, pol, clr;
  logic [3:0] adr, sel;
  logic [31:0] dat, rdat, r, ctl;
  logic [4:0] cnt;
  logic [17:0] rx;
  logic [7:0] c1, c2;
  int err_count = 0, checked = 0, n;
  wire dline = doe_n ? 1'b1 : dout;
  wire cline = coe_n ? pol : cout;
  always #2.5 clk = ~clk;
  sst_master_tx dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_data_in(dline), .o_data_out(dout), .o_data_oe_n(doe_n),
    .o_clk_out(cout), .o_clk_oe_n(coe_n), .o_irq(irq));
  sst_slave_model u_slv (.i_core_clk(clk), .i_clk_line(cline), .i_data_line(dline),
    .i_pol(pol), .i_clr(clr), .o_cnt(cnt), .o_rx(rx));
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) err_count++;
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {rst_n, cyc, stb, we, adr, sel, dat, pol, clr} = {4'h0, 4'h0, 4'h0, 32'h0, 2'b01};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    clr   <= 1'b0;
    wb(0, SST_ADDR_CTRL, 0); chk("ctrl", 0, r);
    wb(0, 4'h2, 0); chk("unmapped", 0, r);
    wb(0, SST_ADDR_TXBUF, 0); chk("txbuf", 0, r);
    chk("clk_oe", 1, 32'(coe_n));
    wb(1, SST_ADDR_BAUD, 32'h105);
    wb(1, SST_ADDR_CTRL, 32'h837);
    repeat (3) @(negedge clk);
    chk("rx_on_oe", 1, 32'(doe_n));
    for (int k = 0; k < 4; k++) begin
      pol <= k[1];
      ctl = 32'h8A7 | (32'(k[1]) << 8) | (32'(k[0]) << 6);
      c1 = 8'hA5 + 8'(k);
      c2 = 8'h3C ^ 8'(k << 4);
      wb(1, SST_ADDR_CTRL, ctl);
      wb(0, SST_ADDR_CTRL, 0); chk("ctrl_rb", ctl, r);
      repeat (140) @(negedge clk);
      chk("idle", 32'(pol), 32'(cline));
      chk("oe", 0, {doe_n, coe_n});
      clr <= 1'b1;
      wb(1, SST_ADDR_TXBUF, c1);
      clr <= 1'b0;
      wb(1, SST_ADDR_TXBUF, c2);
      n = 0;
      while (cnt < 5'(16 + 2 * k[0]) && n < 2000) begin
        @(negedge clk);
        n++;
      end
      repeat (60) @(negedge clk);
      chk("bits", 16 + 2 * k[0], 32'(cnt));
      chk("data", k[0] ? {1'b1, c2, 1'b1, c1} : {c2, c1}, 32'(rx));
      chk("irq", 1, 32'(irq));
      wb(0, SST_ADDR_STATUS, 0); chk("empty", 1, 32'(r[SST_ST_EMPTY]));
      chk("busy", 0, 32'(r[SST_ST_BUSY]));
      chk("st_irq", 1, 32'(r[SST_ST_IRQ]));
      chk("din", 32'(dline), 32'(r[SST_ST_DIN]));
      repeat (2) @(negedge clk);
      chk("irq_clr", 0, 32'(irq));
      chk("rest", 32'(pol), 32'(cline));
    end
    report_and_stop();
  end
endmodule
